// ==== logic/pcc_defs.svh ====
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define PCC_ADDR_CFG 4'h1
`define PCC_ADDR_CTRL1 4'h2
`define PCC_ADDR_CTRL2 4'h3
`define PCC_CTRL1_RST 8'h21
`define PCC_CTRL2_RST 8'h21
`define PCC_CFG_RST 8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCC_C1_PD_GATE 7
`define PCC_C1_ICUT_HI 6
`define PCC_C1_ICUT_LO 5
`define PCC_C1_DLY_HI 4
`define PCC_C1_DLY_LO 3
`define PCC_C1_LATCH 2
`define PCC_C1_DEB_HI 1
`define PCC_C1_DEB_LO 0
`define PCC_C2_AUX_PD 7
`define PCC_C2_PD_STR 5
`define PCC_C2_SUP_COD 4
`define PCC_C2_SUP_DLY 3
`define PCC_C2_SUP_LATCH 2
`define PCC_C2_DEB_HI 1
`define PCC_C2_DEB_LO 0
`define PCC_CFG_MODE_HI 7
`define PCC_CFG_MODE_LO 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCC_CLK_MHZ 125
`define PCC_CLK_NS 8
`define PCC_TICK_CYC (`PCC_CLK_MHZ)
`define PCC_CH_DLY0_US 100
`define PCC_CH_DLY1_US 150
`define PCC_CH_DLY2_US 200
`define PCC_CH_DLY3_US 250
`define PCC_CH_RESTART_MULT 255
`define PCC_DEB0_US 0
`define PCC_DEB1_US 5
`define PCC_DEB2_US 20
`define PCC_DEB3_US 100
`define PCC_SUP_DLY_US 500
`define PCC_SUP_RESTART_MS 64
`define PCC_SUP_RESTART_US (`PCC_SUP_RESTART_MS * 1000)
`define PCC_DEAD_NS 500
`define PCC_DEAD_CYC ((`PCC_DEAD_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)

`endif

// ==== logic/pcc_pkg.sv ====
`include "pcc_defs.svh"

package pcc_pkg;

    typedef enum logic [2:0] {
        PCC_MODE_OFF = 3'h0,
        PCC_MODE_LS = 3'h1,
        PCC_MODE_HS = 3'h2,
        PCC_MODE_PP = 3'h3,
        PCC_MODE_TRI = 3'h4,
        PCC_MODE_LS_ON = 3'h5,
        PCC_MODE_HS_ON = 3'h6,
        PCC_MODE_PP_IND = 3'h7
    } pcc_mode_t;

    typedef enum logic [1:0] {
        PCC_CUT_RUN = 2'h0,
        PCC_CUT_ARM = 2'h1,
        PCC_CUT_OFF = 2'h3
    } pcc_cut_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic seq;
        logic seq_end;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pcc_req_t;

    typedef struct packed {
        logic ch_enable;
        logic drive_in;
        logic sense_line;
        logic aux_line;
        logic ch_overcur;
        logic supply_overcur;
    } pcc_pins_t;

    function automatic logic [7:0] pcc_deb_us(input logic [1:0] code);
        case (code)
            2'h0: pcc_deb_us = 8'(`PCC_DEB0_US);
            2'h1: pcc_deb_us = 8'(`PCC_DEB1_US);
            2'h2: pcc_deb_us = 8'(`PCC_DEB2_US);
            default: pcc_deb_us = 8'(`PCC_DEB3_US);
        endcase
    endfunction

    function automatic logic [8:0] pcc_ch_dly_us(input logic [1:0] code);
        case (code)
            2'h0: pcc_ch_dly_us = 9'(`PCC_CH_DLY0_US);
            2'h1: pcc_ch_dly_us = 9'(`PCC_CH_DLY1_US);
            2'h2: pcc_ch_dly_us = 9'(`PCC_CH_DLY2_US);
            default: pcc_ch_dly_us = 9'(`PCC_CH_DLY3_US);
        endcase
    endfunction

    function automatic logic pcc_active(input logic [2:0] m);
        pcc_active = (m != PCC_MODE_OFF) && (m != PCC_MODE_TRI);
    endfunction

endpackage

// ==== logic/pcc_debounce.sv ====
`timescale 1ns/1ns
`include "pcc_defs.svh"

module pcc_debounce
    import pcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic level,
    input wire logic [1:0] sel,
    output logic level_db
);

    logic [7:0] cnt_r;
    logic [7:0] hold_us;

    assign hold_us = pcc_deb_us(sel);

    // ----------------------------------------------------------------
    // Stability filter
    // ----------------------------------------------------------------
    // One extra tick is counted because the first tick may come at once.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 8'h00;
            level_db <= 1'b0;
        end else if (level == level_db) begin
            cnt_r <= 8'h00;
        end else if (hold_us == 8'h00) begin
            level_db <= level;
        end else if (tick) begin
            if (cnt_r >= hold_us) begin
                level_db <= level;
                cnt_r <= 8'h00;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    property p_deb_zero;
        @(posedge clk) disable iff (reset)
        (hold_us == 8'h00 && level != level_db) |=> level_db == $past(level);
    endproperty
    a_deb_zero: assert property (p_deb_zero) else $error("debounce zero");

endmodule

// ==== logic/pcc_cutoff.sv ====
`timescale 1ns/1ns
`include "pcc_defs.svh"

module pcc_cutoff
    import pcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic overcur,
    input wire logic cut_en,
    input wire logic [8:0] delay_us,
    input wire logic [15:0] restart_us,
    input wire logic latch,
    input wire logic unlatch,
    output logic drv_ok
);

    pcc_cut_t st_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_inc;

    assign cnt_inc = cnt_r + 16'h0001;
    assign drv_ok = (st_r != PCC_CUT_OFF);

    // ----------------------------------------------------------------
    // Cut-off sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= PCC_CUT_RUN;
            cnt_r <= 16'h0000;
        end else begin
            case (st_r)
                PCC_CUT_RUN: begin
                    cnt_r <= 16'h0000;
                    if (cut_en && overcur) begin
                        st_r <= (delay_us == 9'h000) ? PCC_CUT_OFF
                                                     : PCC_CUT_ARM;
                    end
                end
                PCC_CUT_ARM: begin
                    if (!overcur || !cut_en) begin
                        st_r <= PCC_CUT_RUN;
                    end else if (tick) begin
                        cnt_r <= cnt_inc;
                        if (cnt_inc >= {7'h00, delay_us}) begin
                            st_r <= PCC_CUT_OFF;
                            cnt_r <= 16'h0000;
                        end
                    end
                end
                PCC_CUT_OFF: begin
                    if (latch) begin
                        cnt_r <= 16'h0000;
                        if (unlatch) begin
                            st_r <= PCC_CUT_RUN;
                        end
                    end else if (tick) begin
                        cnt_r <= cnt_inc;
                        if (cnt_inc >= restart_us) begin
                            st_r <= PCC_CUT_RUN;
                        end
                    end
                end
                default: st_r <= PCC_CUT_RUN;
            endcase
        end
    end

    property p_unlatch;
        @(posedge clk) disable iff (reset)
        (st_r == PCC_CUT_OFF && latch && unlatch) |=> drv_ok;
    endproperty
    a_unlatch: assert property (p_unlatch) else $error("latch not released");

    property p_latch_holds;
        @(posedge clk) disable iff (reset)
        (st_r == PCC_CUT_OFF && latch && !unlatch) |=> !drv_ok;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latch lost");

    property p_immediate;
        @(posedge clk) disable iff (reset)
        (st_r == PCC_CUT_RUN && cut_en && overcur && delay_us == 9'h000)
            |=> !drv_ok;
    endproperty
    a_immediate: assert property (p_immediate) else $error("no instant trip");

    property p_delayed;
        @(posedge clk) disable iff (reset)
        (st_r == PCC_CUT_RUN && cut_en && overcur && delay_us != 9'h000)
            |=> drv_ok;
    endproperty
    a_delayed: assert property (p_delayed) else $error("trip too early");

    property p_no_cut;
        @(posedge clk) disable iff (reset)
        (st_r == PCC_CUT_RUN && !cut_en) |=> drv_ok;
    endproperty
    a_no_cut: assert property (p_no_cut) else $error("trip while disabled");

endmodule

// ==== logic/pcc_top.sv ====
`timescale 1ns/1ns
`include "pcc_defs.svh"

// How it works
// - Sense pull-down runs only when its gate bit is set and enable low.
// - Two bits pick the channel cut-off current among four levels.
// - Persistent overcurrent turns the channel driver off after a delay.
// - Channel restarts after 255 delays, or stays off until any access.
// - Sense input must hold its new level for the selected debounce time.
// - Auxiliary input pull-down simply follows its control bit.
// - One bit selects normal or low-power sense pull-down strength.
// - Supply cut-off works when its disable bit is clear; keep it so.
// - Supply cut-off delay is 500 us or immediate.
// - Supply switch restarts after 64 ms, or stays off until access.
// - Auxiliary input debounce uses the same four hold times.
// - Off mode keeps both switches and the receiver off.
// - High-side mode drives the high switch when drive low, enable high.
// - Receiver off forces output high; otherwise output is inverted line.
// - Other codes: push-pull, tri-state, forced on; push-pull has dead time.
// - Jumps between active modes are refused with a parity error.
module pcc_top
    import pcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire pcc_req_t req,
    input wire pcc_pins_t pins,
    output logic [7:0] rdata,
    output logic parity_err,
    output logic high_side_switch,
    output logic low_side_switch,
    output logic rx_out,
    output logic sense_pulldown_on,
    output logic sense_pulldown_strength,
    output logic aux_input_pulldown_on,
    output logic [1:0] ch_cutoff_sel,
    output logic aux_level,
    output logic supply_switch_on
);

    // ----------------------------------------------------------------
    // Registers and synchronisers
    // ----------------------------------------------------------------
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [7:0] cfg_r;
    logic [7:0] sh_ctrl1_r;
    logic [7:0] sh_ctrl2_r;
    logic [7:0] sh_cfg_r;
    logic [2:0] sh_dirty_r;
    logic seq_bad_r;
    pcc_pins_t pin_meta_r;
    pcc_pins_t pin_s_r;
    logic [6:0] tick_cnt_r;
    logic tick_r;
    logic [6:0] dead_r;
    logic [6:0] dead_nxt;
    logic hs_nxt;
    logic ls_nxt;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    pcc_mode_t mode;
    logic [2:0] new_mode;
    logic hit_cfg;
    logic hit_c1;
    logic hit_c2;
    logic forbid;
    logic single_wr;
    logic seq_wr;
    logic access;
    logic en_s;
    logic in_s;
    logic sense_db;
    logic ch_ok;
    logic sup_ok;
    logic want_hs;
    logic want_ls;
    logic is_pp;
    logic [7:0] rd_sel;
    logic [8:0] ch_dly;
    logic [15:0] ch_restart;
    logic [8:0] sup_dly;

    assign mode = pcc_mode_t'(cfg_r[`PCC_CFG_MODE_HI:`PCC_CFG_MODE_LO]);
    assign new_mode = req.wdata[`PCC_CFG_MODE_HI:`PCC_CFG_MODE_LO];
    assign hit_cfg = (req.addr == `PCC_ADDR_CFG);
    assign hit_c1 = (req.addr == `PCC_ADDR_CTRL1);
    assign hit_c2 = (req.addr == `PCC_ADDR_CTRL2);
    assign forbid = hit_cfg && pcc_active(mode) && pcc_active(new_mode)
                    && (new_mode != mode);
    assign single_wr = req.wr && !req.seq;
    assign seq_wr = req.wr && req.seq;
    assign access = req.wr || req.rd;
    assign en_s = pin_s_r.ch_enable;
    assign in_s = pin_s_r.drive_in;

    always_comb begin
        if (hit_cfg) begin
            rd_sel = cfg_r;
        end else if (hit_c1) begin
            rd_sel = ctrl1_r;
        end else if (hit_c2) begin
            rd_sel = ctrl2_r;
        end else begin
            rd_sel = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // A sequential write is staged and committed whole at its end, so a
    // forbidden mode jump can throw away every register of the burst.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl1_r <= `PCC_CTRL1_RST;
            ctrl2_r <= `PCC_CTRL2_RST;
            cfg_r <= `PCC_CFG_RST;
            sh_ctrl1_r <= 8'h00;
            sh_ctrl2_r <= 8'h00;
            sh_cfg_r <= 8'h00;
            sh_dirty_r <= 3'h0;
            seq_bad_r <= 1'b0;
            parity_err <= 1'b0;
            rdata <= 8'h00;
        end else begin
            parity_err <= 1'b0;
            if (req.rd) begin
                rdata <= rd_sel;
            end
            if (single_wr) begin
                if (hit_c1) begin
                    ctrl1_r <= req.wdata;
                end else if (hit_c2) begin
                    ctrl2_r <= req.wdata;
                end else if (hit_cfg && !forbid) begin
                    cfg_r <= req.wdata;
                end
                if (forbid) begin
                    parity_err <= 1'b1;
                end
            end else if (seq_wr) begin
                if (hit_c1) begin
                    sh_ctrl1_r <= req.wdata;
                    sh_dirty_r[0] <= 1'b1;
                end else if (hit_c2) begin
                    sh_ctrl2_r <= req.wdata;
                    sh_dirty_r[1] <= 1'b1;
                end else if (hit_cfg) begin
                    sh_cfg_r <= req.wdata;
                    sh_dirty_r[2] <= 1'b1;
                end
                if (forbid) begin
                    seq_bad_r <= 1'b1;
                end
            end else if (req.seq_end) begin
                sh_dirty_r <= 3'h0;
                seq_bad_r <= 1'b0;
                if (seq_bad_r) begin
                    parity_err <= 1'b1;
                end else begin
                    if (sh_dirty_r[0]) begin
                        ctrl1_r <= sh_ctrl1_r;
                    end
                    if (sh_dirty_r[1]) begin
                        ctrl2_r <= sh_ctrl2_r;
                    end
                    if (sh_dirty_r[2]) begin
                        cfg_r <= sh_cfg_r;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and microsecond tick
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta_r <= '0;
            pin_s_r <= '0;
            tick_cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            pin_meta_r <= pins;
            pin_s_r <= pin_meta_r;
            tick_r <= (tick_cnt_r == 7'(`PCC_TICK_CYC - 1));
            if (tick_cnt_r == 7'(`PCC_TICK_CYC - 1)) begin
                tick_cnt_r <= 7'h00;
            end else begin
                tick_cnt_r <= tick_cnt_r + 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Debounce and cut-off
    // ----------------------------------------------------------------
    // sense debounce
    pcc_debounce u_deb_sense (
        .clk(clk),
        .reset(reset),
        .tick(tick_r),
        .level(pin_s_r.sense_line),
        .sel(ctrl1_r[`PCC_C1_DEB_HI:`PCC_C1_DEB_LO]),
        .level_db(sense_db)
    );

    pcc_debounce u_deb_aux (
        .clk(clk),
        .reset(reset),
        .tick(tick_r),
        .level(pin_s_r.aux_line),
        .sel(ctrl2_r[`PCC_C2_DEB_HI:`PCC_C2_DEB_LO]),
        .level_db(aux_level)
    );

    assign ch_dly = pcc_ch_dly_us(ctrl1_r[`PCC_C1_DLY_HI:`PCC_C1_DLY_LO]);
    assign ch_restart = 16'(ch_dly * `PCC_CH_RESTART_MULT);
    assign sup_dly = ctrl2_r[`PCC_C2_SUP_DLY] ? 9'h000
                                              : 9'(`PCC_SUP_DLY_US);

    pcc_cutoff u_cut_ch (
        .clk(clk),
        .reset(reset),
        .tick(tick_r),
        .overcur(pin_s_r.ch_overcur),
        .cut_en(1'b1),
        .delay_us(ch_dly),
        .restart_us(ch_restart),
        .latch(ctrl1_r[`PCC_C1_LATCH]),
        .unlatch(access),
        .drv_ok(ch_ok)
    );

    // disable bit; 64 ms or latched
    pcc_cutoff u_cut_sup (
        .clk(clk),
        .reset(reset),
        .tick(tick_r),
        .overcur(pin_s_r.supply_overcur),
        .cut_en(!ctrl2_r[`PCC_C2_SUP_COD]),
        .delay_us(sup_dly),
        .restart_us(16'(`PCC_SUP_RESTART_US)),
        .latch(ctrl2_r[`PCC_C2_SUP_LATCH]),
        .unlatch(access),
        .drv_ok(sup_ok)
    );

    // ----------------------------------------------------------------
    // Output stage
    // ----------------------------------------------------------------
    // switch demand per mode
    assign is_pp = (mode == PCC_MODE_PP) || (mode == PCC_MODE_PP_IND);
    assign want_hs = ch_ok
                     && (((mode == PCC_MODE_HS || is_pp) && en_s && !in_s)
                     || mode == PCC_MODE_HS_ON);
    assign want_ls = ch_ok
                     && (((mode == PCC_MODE_LS || is_pp) && en_s && in_s)
                     || mode == PCC_MODE_LS_ON);

    always_comb begin
        hs_nxt = want_hs;
        ls_nxt = want_ls;
        dead_nxt = 7'h00;
        if (is_pp) begin
            if ((high_side_switch && !want_hs)
                || (low_side_switch && !want_ls)) begin
                hs_nxt = high_side_switch && want_hs;
                ls_nxt = low_side_switch && want_ls;
                dead_nxt = 7'(`PCC_DEAD_CYC);
            end else if (dead_r != 7'h00) begin
                hs_nxt = high_side_switch;
                ls_nxt = low_side_switch;
                dead_nxt = dead_r - 7'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            high_side_switch <= 1'b0;
            low_side_switch <= 1'b0;
            dead_r <= 7'h00;
            rx_out <= 1'b1;
            sense_pulldown_on <= 1'b0;
            sense_pulldown_strength <= 1'b0;
            aux_input_pulldown_on <= 1'b0;
            ch_cutoff_sel <= 2'h0;
            supply_switch_on <= 1'b0;
        end else begin
            high_side_switch <= hs_nxt;
            low_side_switch <= ls_nxt;
            dead_r <= dead_nxt;
            rx_out <= (mode == PCC_MODE_OFF) || en_s || !sense_db;
            sense_pulldown_on <= ctrl1_r[`PCC_C1_PD_GATE] && !en_s;
            sense_pulldown_strength <= ctrl2_r[`PCC_C2_PD_STR];
            aux_input_pulldown_on <= ctrl2_r[`PCC_C2_AUX_PD];
            ch_cutoff_sel <= ctrl1_r[`PCC_C1_ICUT_HI:`PCC_C1_ICUT_LO];
            supply_switch_on <= sup_ok;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_bad_cfg_wr;
        single_wr && forbid;
    endsequence

    property p_refuse;
        @(posedge clk) disable iff (reset)
        s_bad_cfg_wr |=> parity_err && cfg_r == $past(cfg_r);
    endproperty
    a_refuse: assert property (p_refuse) else $error("jump taken");

    property p_off_mode;
        @(posedge clk) disable iff (reset)
        (mode == PCC_MODE_OFF)[*2] |-> !high_side_switch && !low_side_switch
            && rx_out;
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("off drives");

    property p_ls_mode;
        @(posedge clk) disable iff (reset)
        (mode == PCC_MODE_LS)[*2] |-> !high_side_switch;
    endproperty
    a_ls_mode: assert property (p_ls_mode) else $error("hs in ls mode");

    property p_hs_mode;
        @(posedge clk) disable iff (reset)
        (mode == PCC_MODE_HS)[*2] |-> !low_side_switch;
    endproperty
    a_hs_mode: assert property (p_hs_mode) else $error("ls in hs mode");

    property p_rx_off;
        @(posedge clk) disable iff (reset)
        en_s |=> rx_out;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx not high");

    property p_pd_gate;
        @(posedge clk) disable iff (reset)
        (!ctrl1_r[`PCC_C1_PD_GATE] || en_s) |=> !sense_pulldown_on;
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("pull-down on");

    property p_aux_pd;
        @(posedge clk) disable iff (reset)
        ##1 aux_input_pulldown_on == $past(ctrl2_r[`PCC_C2_AUX_PD]);
    endproperty
    a_aux_pd: assert property (p_aux_pd) else $error("aux pd wrong");

    property p_no_overlap;
        @(posedge clk) disable iff (reset)
        !(high_side_switch && low_side_switch);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("overlap");

endmodule

// ==== sim/pcc_host.sv ====
`timescale 1ns/1ns
module pcc_host
    import pcc_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output pcc_req_t req
);
    initial req = '0;
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1 req.rd = 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic burst(input logic [7:0] c1, input logic [7:0] cf);
        req.seq = 1'b1;
        req.wr = 1'b1;
        req.addr = 4'h2;
        req.wdata = c1;
        @(posedge clk);
        #1 req.addr = 4'h1;
        req.wdata = cf;
        @(posedge clk);
        #1 req.wr = 1'b0;
        req.seq = 1'b0;
        req.seq_end = 1'b1;
        @(posedge clk);
        #1 req.seq_end = 1'b0;
    endtask
endmodule

// ==== sim/pcc_top_bench.sv ====
`timescale 1ns/1ns
module pcc_top_bench
    import pcc_pkg::*;
;
    logic clk, reset, perr, hs, ls, rx, pd_on, pd_str, aux_pd, seen;
    logic aux, sup;
    logic [7:0] rdata, rd;
    logic [1:0] cut;
    logic [15:0] lf;
    pcc_req_t req;
    pcc_pins_t pins;
    int n_fail, n_compared, regs[4];
    int modes[13] = '{1, 2, 0, 2, 4, 5, 6, 0, 6, 0, 7, 4, 3};
    int deb[4] = '{0, 5, 20, 100};
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    pcc_top uut(.clk(clk), .reset(reset), .req(req), .pins(pins),
        .rdata(rdata), .parity_err(perr), .high_side_switch(hs),
        .low_side_switch(ls), .rx_out(rx), .sense_pulldown_on(pd_on),
        .sense_pulldown_strength(pd_str), .aux_input_pulldown_on(aux_pd),
        .ch_cutoff_sel(cut), .aux_level(aux), .supply_switch_on(sup));
    pcc_host host(.clk(clk), .rdata(rdata), .req(req));
    function automatic logic [15:0] step(input logic [15:0] s);
        step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic bit busy(input int m);
        return m != 0 && m != 4;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // The error pulse stands for one cycle, so it is caught on return.
    task automatic expect_err(input bit bad);
        seen = perr;
        repeat (3) begin
            @(posedge clk);
            #1 seen = seen | perr;
        end
        check(8'(seen), 8'(bad));
    endtask
    task automatic seq(input logic [7:0] c1, input logic [7:0] cf);
        bit bad;
        bad = busy(regs[1] >> 5) && busy(cf >> 5)
            && (regs[1] >> 5) != (cf >> 5);
        if (!bad) begin
            regs[2] = c1;
            regs[1] = cf;
        end
        host.burst(c1, cf);
        expect_err(bad);
        host.get(2, rd);
        check(rd, 8'(regs[2]));
        host.get(1, rd);
        check(rd, 8'(regs[1]));
    endtask
    task automatic put(input int a, input logic [7:0] d);
        bit bad;
        bad = a == 1 && busy(regs[1] >> 5) && busy(d >> 5)
            && (regs[1] >> 5) != (d >> 5);
        if (!bad && a >= 1 && a <= 3) regs[a] = d;
        host.put(4'(a), d);
        expect_err(bad);
    endtask
    // Waits past both debounce times and the push-pull dead time.
    task automatic pin(input logic en, input logic dv, input logic sl,
                       input logic ax);
        int m;
        int w;
        logic [2:0] e;
        pins.ch_enable = en;
        pins.drive_in = dv;
        pins.sense_line = sl;
        pins.aux_line = ax;
        w = deb[regs[2][1:0]];
        if (deb[regs[3][1:0]] > w) w = deb[regs[3][1:0]];
        repeat (70 + 125 * (w + 1)) @(posedge clk);
        #1 m = regs[1] >> 5;
        e[2] = ((m == 2 || m == 3 || m == 7) && !dv && en) || m == 6;
        e[1] = ((m == 1 || m == 3 || m == 7) && dv && en) || m == 5;
        e[0] = (m == 0 || en) ? 1'b1 : !sl;
        check({5'h0, hs, ls, rx}, {5'h0, e});
        check({7'h0, pd_on}, 8'(regs[2][7] && !en));
        check({7'h0, aux}, {7'h0, ax});
    endtask
    initial begin
        reset = 1;
        pins = '0;
        lf = 16'd25563;
        regs = '{0, 8'h80, 8'h21, 8'h21};
        repeat (12) @(posedge clk);
        #1 reset = 0;
        @(posedge clk);
        #1;
        for (int a = 1; a <= 5; a++) begin
            host.get(4'(a), rd);
            check(rd, 8'(a <= 3 ? regs[a] : 0));
        end
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            lf = step(lf);
            put(2, lf[7:0]);
            put(3, lf[15:8] & 8'hef);
            host.get(2, rd);
            check(rd, 8'(regs[2]));
            host.get(3, rd);
            check(rd, 8'(regs[3]));
            check({6'h0, cut}, 8'(regs[2][6:5]));
            check({7'h0, aux_pd}, 8'(regs[3][7]));
            check({7'h0, pd_str}, 8'(regs[3][5]));
            pin(lf[0], lf[1], lf[2], lf[3]);
        end
        $display("control registers done");
        put(2, 8'(regs[2]) & 8'hfc);
        put(3, 8'(regs[3]) & 8'hfc);
        foreach (modes[i]) begin
            lf = step(lf);
            if (modes[i] == 2) put(2, 8'(regs[2]) & 8'h7f);
            put(1, {3'(modes[i]), 5'h0});
            host.get(1, rd);
            check(rd, 8'(regs[1]));
            pin(1'b1, lf[0], lf[1], lf[4]);
            pin(1'b0, lf[2], lf[3], lf[5]);
        end
        $display("output modes done");
        put(1, 8'h80);
        put(1, 8'ha0);
        put(2, 8'h04);
        put(3, 8'h0c);
        pins.supply_overcur = 1'b1;
        repeat (6) @(posedge clk);
        #1 check({7'h0, sup}, 8'h00);
        pins.supply_overcur = 1'b0;
        repeat (100) @(posedge clk);
        #1 check({7'h0, sup}, 8'h00);
        host.get(0, rd);
        check({7'h0, sup}, 8'h01);
        put(3, 8'h1c);
        pins.supply_overcur = 1'b1;
        repeat (6) @(posedge clk);
        #1 check({7'h0, sup}, 8'h01);
        pins.supply_overcur = 1'b0;
        pins.ch_overcur = 1'b1;
        repeat (12000) @(posedge clk);
        #1 check({7'h0, ls}, 8'h01);
        repeat (1000) @(posedge clk);
        #1 check({7'h0, ls}, 8'h00);
        pins.ch_overcur = 1'b0;
        repeat (100) @(posedge clk);
        #1 check({7'h0, ls}, 8'h00);
        host.get(0, rd);
        check({7'h0, ls}, 8'h01);
        $display("cut-off done");
        lf = step(lf);
        seq(lf[7:0], 8'h20);
        seq(lf[15:8], 8'ha0);
        $display("bursts done");
        complete_run();
    end
endmodule
